//--- asp_pkg.sv
//------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------
package asp_pkg;

  //------------------------------------------------------------------
  // Timing
  //------------------------------------------------------------------
  localparam int unsigned CLK_HZ   = 10_000_000;
  localparam int unsigned BAUD_HZ  = 9600;
  localparam int unsigned BIT_CYC  = CLK_HZ / BAUD_HZ;

  //------------------------------------------------------------------
  // Register map, byte addresses
  //------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_TXDATA  = 8'h04;
  localparam logic [7:0] OFS_RXDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_INTSTAT = 8'h10;
  localparam logic [7:0] OFS_INTMASK = 8'h14;

  // Field positions.
  localparam int unsigned BIT_TXREQ  = 0;
  localparam int unsigned BIT_TXEV   = 0;
  localparam int unsigned BIT_RXEV   = 1;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_INT  = 2'h0;

  typedef struct packed {
    logic rxBusy;
    logic rxDone;
    logic txBusy;
  } asp_stat_t;

  typedef enum logic [1:0] {RX_SEARCH, RX_DATA, RX_STOP} asp_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} asp_tx_t;

endpackage

//--- asp_serial_port.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
module asp_serial_port #(
  parameter int unsigned BIT_DIV   = asp_pkg::BIT_CYC,
  parameter bit          DATA8     = 1'b1,
  parameter bit          TWO_STOP  = 1'b0,
  parameter bit          LSB_FIRST = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin,
  output logic             irq
);

  //------------------------------------------------------------------
  // Derived counts
  //------------------------------------------------------------------
  // divider sets rate
  localparam logic [15:0] BIT_CNT   = 16'(BIT_DIV - 1);
  localparam logic [15:0] HALF_CNT  = 16'(BIT_DIV / 2 - 1);
  localparam logic [15:0] FIRST_CNT = 16'((BIT_DIV * 5) / 4 - 1);
  localparam logic [15:0] STOP_CNT  = 16'((TWO_STOP ? 2 : 1) * BIT_DIV - 1);
  localparam logic [3:0]  NBITS     = DATA8 ? 4'h8 : 4'h7;

  //------------------------------------------------------------------
  // Pin input synchroniser
  //------------------------------------------------------------------
  logic rxMeta_ff;
  logic rxIn_ff;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rxMeta_ff <= 1'b1;
      rxIn_ff   <= 1'b1;
    end
    else
    begin
      rxMeta_ff <= serial_rx_pin;
      rxIn_ff   <= rxMeta_ff;
    end

  //------------------------------------------------------------------
  // APB decode
  //------------------------------------------------------------------
  logic [7:0] txData_ff;
  logic [7:0] rx_shift_register_ff;
  logic       txReq_ff;
  logic       rxDone_ff;
  logic [1:0] intStat_ff;
  logic [1:0] intMask_ff;
  logic       txDoneEv;
  logic       rxDoneEv;
  asp_pkg::asp_stat_t stat;
  asp_pkg::asp_rx_t   rxState_ff;
  asp_pkg::asp_tx_t   txState_ff;

  wire access   = psel & penable;
  wire selCtrl  = paddr == asp_pkg::OFS_CTRL;
  wire selTx    = paddr == asp_pkg::OFS_TXDATA;
  wire selRx    = paddr == asp_pkg::OFS_RXDATA;
  wire selStat  = paddr == asp_pkg::OFS_STATUS;
  wire selIst   = paddr == asp_pkg::OFS_INTSTAT;
  wire selImsk  = paddr == asp_pkg::OFS_INTMASK;
  wire mapped   = selCtrl | selTx | selRx | selStat | selIst | selImsk;
  wire wrEn     = access & pwrite & mapped;
  wire txReqSet = wrEn & selCtrl & pwdata[asp_pkg::BIT_TXREQ];
  wire [1:0] intClr = (wrEn & selIst) ? pwdata[1:0] : 2'h0;

  assign stat = '{rxBusy: rxState_ff == asp_pkg::RX_DATA, rxDone: rxDone_ff, txBusy: txReq_ff};

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = !access    ? 32'h0 :
                   selCtrl    ? {31'h0, txReq_ff} :
                   selTx      ? {24'h0, txData_ff} :
                   selRx      ? {24'h0, rx_shift_register_ff} :
                   selStat    ? {29'h0, stat} :
                   selIst     ? {30'h0, intStat_ff} :
                   selImsk    ? {30'h0, intMask_ff} : 32'h0;

  //------------------------------------------------------------------
  // Interrupt status and mask
  //------------------------------------------------------------------
  wire [1:0] intSet = {rxDoneEv, txDoneEv};
  // A new event wins over a clear written in the same cycle.
  wire [1:0] nxt_intStat = (intStat_ff & ~intClr) | intSet;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      intStat_ff <= asp_pkg::RST_INT;
      intMask_ff <= asp_pkg::RST_INT;
      txData_ff  <= asp_pkg::RST_BYTE;
    end
    else
    begin
      intStat_ff <= nxt_intStat;
      if (wrEn & selImsk)
        intMask_ff <= pwdata[1:0];
      if (wrEn & selTx)
        txData_ff <= pwdata[7:0];
    end

  assign irq = |(intStat_ff & intMask_ff);

  //------------------------------------------------------------------
  // Receiver
  //------------------------------------------------------------------
  logic [15:0] rxCnt_ff;
  logic [3:0]  rxLeft_ff;
  wire         rxTick = rxCnt_ff == 16'h0;
  wire [7:0] rxShifted = LSB_FIRST ? (DATA8 ? {rxIn_ff, rx_shift_register_ff[7:1]}
                                            : {1'b0, rxIn_ff, rx_shift_register_ff[6:1]})
                                   : (DATA8 ? {rx_shift_register_ff[6:0], rxIn_ff}
                                            : {1'b0, rx_shift_register_ff[5:0], rxIn_ff});
  wire rxStart = rxState_ff == asp_pkg::RX_SEARCH && rxTick && !rxIn_ff;
  wire rxLast  = rxState_ff == asp_pkg::RX_DATA && rxTick && rxLeft_ff == 4'h1;
  assign rxDoneEv = rxLast;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rxState_ff           <= asp_pkg::RX_SEARCH;
      rxCnt_ff             <= 16'h0;
      rxLeft_ff            <= 4'h0;
      rx_shift_register_ff <= asp_pkg::RST_BYTE;
      rxDone_ff            <= 1'b0;
    end
    else
    begin
      if (!rxTick)
        rxCnt_ff <= rxCnt_ff - 16'h1;
      case (rxState_ff)
        asp_pkg::RX_SEARCH:
          if (rxTick)
          begin
            if (!rxIn_ff)
            begin
              rx_shift_register_ff <= 8'h00;
              rxDone_ff            <= 1'b0;
              rxLeft_ff            <= NBITS;
              rxCnt_ff             <= FIRST_CNT;
              rxState_ff           <= asp_pkg::RX_DATA;
            end
            else
              rxCnt_ff <= HALF_CNT;
          end
        asp_pkg::RX_DATA:
          if (rxTick)
          begin
            rx_shift_register_ff <= rxShifted;
            rxLeft_ff            <= rxLeft_ff - 4'h1;
            rxCnt_ff             <= BIT_CNT;
            if (rxLeft_ff == 4'h1)
            begin
              rxDone_ff  <= 1'b1;
              rxState_ff <= asp_pkg::RX_STOP;
            end
          end
        asp_pkg::RX_STOP:
          // Waiting out the stop bit keeps a low last data bit from faking a start.
          if (rxTick)
            rxState_ff <= asp_pkg::RX_SEARCH;
        default:
          rxState_ff <= asp_pkg::RX_SEARCH;
      endcase
    end

  //------------------------------------------------------------------
  // Transmitter
  //------------------------------------------------------------------
  logic [7:0]  tx_shift_register_ff;
  logic [15:0] txCnt_ff;
  logic [3:0]  txLeft_ff;
  logic        txPin_ff;
  wire         txTick = txCnt_ff == 16'h0;
  wire [7:0] txShifted = LSB_FIRST ? {1'b0, tx_shift_register_ff[7:1]}
                                   : {tx_shift_register_ff[6:0], 1'b0};
  wire txCurBit  = LSB_FIRST ? tx_shift_register_ff[0]
                             : (DATA8 ? tx_shift_register_ff[7] : tx_shift_register_ff[6]);
  wire txNextBit = LSB_FIRST ? txShifted[0] : (DATA8 ? txShifted[7] : txShifted[6]);
  assign txDoneEv = txState_ff == asp_pkg::TX_STOP && txTick;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      txState_ff           <= asp_pkg::TX_IDLE;
      txCnt_ff             <= 16'h0;
      txLeft_ff            <= 4'h0;
      tx_shift_register_ff <= asp_pkg::RST_BYTE;
      txPin_ff             <= 1'b1;
      txReq_ff             <= 1'b0;
    end
    else
    begin
      if (txReqSet)
        txReq_ff <= 1'b1;
      else if (txDoneEv)
        txReq_ff <= 1'b0;
      if (!txTick)
        txCnt_ff <= txCnt_ff - 16'h1;
      case (txState_ff)
        asp_pkg::TX_IDLE:
          if (txReq_ff)
          begin
            tx_shift_register_ff <= txData_ff;
            txPin_ff             <= 1'b0;
            txCnt_ff             <= BIT_CNT;
            txState_ff           <= asp_pkg::TX_START;
          end
        asp_pkg::TX_START:
          if (txTick)
          begin
            txPin_ff   <= txCurBit;
            txLeft_ff  <= NBITS;
            txCnt_ff   <= BIT_CNT;
            txState_ff <= asp_pkg::TX_DATA;
          end
        asp_pkg::TX_DATA:
          if (txTick)
          begin
            if (txLeft_ff == 4'h1)
            begin
              txPin_ff   <= 1'b1;
              txCnt_ff   <= STOP_CNT;
              txState_ff <= asp_pkg::TX_STOP;
            end
            else
            begin
              tx_shift_register_ff <= txShifted;
              txPin_ff             <= txNextBit;
              txLeft_ff            <= txLeft_ff - 4'h1;
              txCnt_ff             <= BIT_CNT;
            end
          end
        asp_pkg::TX_STOP:
          if (txTick)
            txState_ff <= asp_pkg::TX_IDLE;
        default:
          txState_ff <= asp_pkg::TX_IDLE;
      endcase
    end

  assign serial_tx_pin = txPin_ff;

  //------------------------------------------------------------------
  // Checks
  //------------------------------------------------------------------
  property p_search_poll;
    @(posedge clk) disable iff (!arst_n)
    (rxState_ff == asp_pkg::RX_SEARCH && rxTick && rxIn_ff) |=> rxCnt_ff == HALF_CNT;
  endproperty
  a_search_poll: assert property (p_search_poll)
    else $error("Start search poll period wrong.");

  property p_first_sample;
    @(posedge clk) disable iff (!arst_n)
    rxStart |=> rxCnt_ff == FIRST_CNT && rxState_ff == asp_pkg::RX_DATA
                && rx_shift_register_ff == 8'h00 && !rxDone_ff;
  endproperty
  a_first_sample: assert property (p_first_sample)
    else $error("First sample delay or clear wrong.");

  property p_bit_spacing;
    @(posedge clk) disable iff (!arst_n)
    (rxState_ff == asp_pkg::RX_DATA && rxTick) |=> rxCnt_ff == BIT_CNT
                && rx_shift_register_ff == $past(rxShifted);
  endproperty
  a_bit_spacing: assert property (p_bit_spacing)
    else $error("Data sample spacing wrong.");

  property p_rx_done;
    @(posedge clk) disable iff (!arst_n)
    $rose(rxDone_ff) |-> $past(rxLast);
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("Receive done raised outside frame end.");

  property p_start_low;
    @(posedge clk) disable iff (!arst_n)
    txState_ff == asp_pkg::TX_START |-> !serial_tx_pin;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("Start bit not low.");

  property p_data_bit;
    @(posedge clk) disable iff (!arst_n)
    txState_ff == asp_pkg::TX_DATA |-> serial_tx_pin == txCurBit;
  endproperty
  a_data_bit: assert property (p_data_bit)
    else $error("Data bit on pin does not match register.");

  property p_stop_high;
    @(posedge clk) disable iff (!arst_n)
    (txState_ff == asp_pkg::TX_DATA && txTick && txLeft_ff == 4'h1)
      |=> serial_tx_pin && txCnt_ff == STOP_CNT;
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("Stop bit not high for its length.");

  property p_req_clear;
    @(posedge clk) disable iff (!arst_n)
    (txDoneEv && !txReqSet) |=> !txReq_ff && txState_ff == asp_pkg::TX_IDLE;
  endproperty
  a_req_clear: assert property (p_req_clear)
    else $error("Transmit request not cleared at frame end.");

  property p_idle_high;
    @(posedge clk) disable iff (!arst_n)
    txState_ff == asp_pkg::TX_IDLE |-> serial_tx_pin;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("Transmit pin not idle high.");

endmodule

//--- asp_remote_port.sv
module asp_remote_port #(
  parameter int unsigned BIT_DIV   = 16,
  parameter bit          DATA8     = 1'b1,
  parameter bit          TWO_STOP  = 1'b0,
  parameter bit          LSB_FIRST = 1'b1
) (
  input  wire logic clk,
  input  wire logic lineIn,
  output logic      lineOut
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int NB = DATA8 ? 8 : 7;
  localparam int NS = TWO_STOP ? 2 : 1;

  logic [7:0] gotByte;
  int         gotCount = 0;
  int         frameBad = 0;

  initial lineOut = 1'b1;

  //------------------------------------------------------------------
  // Receiver
  //------------------------------------------------------------------
  // Samples mid-bit, so a start or stop bit off by more than half a bit shows up.
  always
  begin
    @(negedge lineIn);
    gotByte = 8'h00;
    repeat (BIT_DIV / 2) @(posedge clk);
    if (lineIn !== 1'b0) frameBad++;
    for (int i = 0; i < NB; i++)
    begin
      repeat (BIT_DIV) @(posedge clk);
      gotByte[LSB_FIRST ? i : NB - 1 - i] = lineIn;
    end
    for (int s = 0; s < NS; s++)
    begin
      repeat (BIT_DIV) @(posedge clk);
      if (lineIn !== 1'b1) frameBad++;
    end
    gotCount++;
  end

  //------------------------------------------------------------------
  // Transmitter
  //------------------------------------------------------------------
  // The line returns to its idle high level after the stop bit.
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    lineOut <= 1'b0;
    repeat (BIT_DIV) @(posedge clk);
    for (int i = 0; i < NB; i++)
    begin
      lineOut <= b[LSB_FIRST ? i : NB - 1 - i];
      repeat (BIT_DIV) @(posedge clk);
    end
    lineOut <= 1'b1;
    repeat (NS * BIT_DIV) @(posedge clk);
  endtask
endmodule

//--- async_serial_port_two_pin_test.sv
module async_serial_port_two_pin_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned DIV = 16;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxPin;
  logic        txPin;
  logic        irq;
  logic        useAlt = 1'b0;
  logic [31:0] prdataAlt;
  logic        preadyAlt;
  logic        pslverrAlt;
  logic        rxPinAlt;
  logic        txPinAlt;
  logic        irqAlt;
  logic [31:0] d;
  logic        e;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;

  always #50 clk = ~clk;

  asp_serial_port #(.BIT_DIV(DIV)) uut (
    .clk(clk), .arst_n(arst_n), .psel(psel & ~useAlt), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_pin(rxPin), .serial_tx_pin(txPin), .irq(irq)
  );

  asp_remote_port #(.BIT_DIV(DIV)) remote (.clk(clk), .lineIn(txPin), .lineOut(rxPin));

  asp_serial_port #(.BIT_DIV(DIV), .DATA8(1'b0), .TWO_STOP(1'b1), .LSB_FIRST(1'b0)) uutAlt (
    .clk(clk), .arst_n(arst_n), .psel(psel & useAlt), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdataAlt), .pready(preadyAlt),
    .pslverr(pslverrAlt), .serial_rx_pin(rxPinAlt), .serial_tx_pin(txPinAlt), .irq(irqAlt)
  );

  asp_remote_port #(.BIT_DIV(DIV), .DATA8(1'b0), .TWO_STOP(1'b1), .LSB_FIRST(1'b0)) remoteAlt (
    .clk(clk), .lineIn(txPinAlt), .lineOut(rxPinAlt)
  );

  //------------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= w;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while ((useAlt ? preadyAlt : pready) !== 1'b1);
    d = useAlt ? prdataAlt : prdata;
    e = useAlt ? pslverrAlt : pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // The idle edge lets register effects settle before callers look at pins,
    // and keeps back-to-back calls from assigning psel twice in one time step.
    @(posedge clk);
  endtask

  // Polls a status bit until it reaches the wanted value or the poll budget runs out.
  task automatic waitFlag(input int b, input logic v);
    for (int i = 0; i < 400; i++)
    begin
      apb(1'b0, asp_pkg::OFS_STATUS, 32'h0);
      if (d[b] === v) break;
    end
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d errors=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      tally_and_finish;
    end
  end

  //------------------------------------------------------------------
  // Tests
  //------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check({31'h0, txPin}, 32'h1);
    check({31'h0, irq}, 32'h0);
    for (int a = 0; a < 6; a++)
    begin
      apb(1'b0, 8'(a * 4), 32'h0);
      check(d, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, e}, 32'h1);
    $display("reset test done");

    apb(1'b1, asp_pkg::OFS_INTMASK, 32'h3);
    apb(1'b1, asp_pkg::OFS_TXDATA, 32'ha5);
    apb(1'b1, asp_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, asp_pkg::OFS_TXDATA, 32'hff);
    apb(1'b0, asp_pkg::OFS_STATUS, 32'h0);
    check(d & 32'h1, 32'h1);
    for (int i = 0; i < 400 && remote.gotCount == 0; i++) @(posedge clk);
    check({24'h0, remote.gotByte}, 32'ha5);
    check(remote.frameBad, 0);
    waitFlag(0, 1'b0);
    apb(1'b0, asp_pkg::OFS_CTRL, 32'h0);
    check(d, 32'h0);
    apb(1'b0, asp_pkg::OFS_INTSTAT, 32'h0);
    check(d, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, asp_pkg::OFS_INTSTAT, 32'h1);
    check({31'h0, irq}, 32'h0);
    $display("transmit test done");

    remote.send(8'h3c);
    waitFlag(1, 1'b1);
    apb(1'b0, asp_pkg::OFS_RXDATA, 32'h0);
    check(d, 32'h3c);
    fork
      remote.send(8'h81);
    join_none
    repeat (12) @(posedge clk);
    apb(1'b0, asp_pkg::OFS_STATUS, 32'h0);
    check(d & 32'h2, 32'h0);
    check(d & 32'h4, 32'h4);
    apb(1'b0, asp_pkg::OFS_RXDATA, 32'h0);
    check(d, 32'h0);
    waitFlag(1, 1'b1);
    apb(1'b0, asp_pkg::OFS_RXDATA, 32'h0);
    check(d, 32'h81);
    $display("receive test done");

    apb(1'b1, asp_pkg::OFS_INTSTAT, 32'h3);
    apb(1'b1, asp_pkg::OFS_INTMASK, 32'h2);
    // Both directions at once: the receiver must not lose bits while sending.
    fork
      remote.send(8'hc3);
    join_none
    apb(1'b1, asp_pkg::OFS_TXDATA, 32'h5a);
    apb(1'b1, asp_pkg::OFS_CTRL, 32'h1);
    waitFlag(0, 1'b0);
    waitFlag(1, 1'b1);
    apb(1'b0, asp_pkg::OFS_RXDATA, 32'h0);
    check(d, 32'hc3);
    check({24'h0, remote.gotByte}, 32'h5a);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, asp_pkg::OFS_INTSTAT, 32'h2);
    apb(1'b0, asp_pkg::OFS_INTSTAT, 32'h0);
    check(d, 32'h1);
    check({31'h0, irq}, 32'h0);
    $display("duplex test done");

    // Second port: seven data bits, MSB first, two stop bits.
    useAlt <= 1'b1;
    apb(1'b1, asp_pkg::OFS_TXDATA, 32'hcb);
    apb(1'b1, asp_pkg::OFS_CTRL, 32'h1);
    waitFlag(0, 1'b0);
    check({24'h0, remoteAlt.gotByte}, 32'h4b);
    check(remoteAlt.frameBad, 0);
    remoteAlt.send(8'hb5);
    waitFlag(1, 1'b1);
    apb(1'b0, asp_pkg::OFS_RXDATA, 32'h0);
    check(d, 32'h35);
    check({31'h0, irqAlt}, 32'h0);
    $display("frame option test done");

    useAlt <= 1'b0;
    apb(1'b1, asp_pkg::OFS_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    check({31'h0, txPin}, 32'h0);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check({31'h0, txPin}, 32'h1);
    apb(1'b0, asp_pkg::OFS_STATUS, 32'h0);
    check(d, 32'h0);
    apb(1'b0, asp_pkg::OFS_INTSTAT, 32'h0);
    check(d, 32'h0);
    $display("mid-run reset test done");
    tally_and_finish;
  end
endmodule
